// ### esu_defs.svh
// Constants for the endian swap and steer unit
`ifndef ESU_DEFS_SVH
`define ESU_DEFS_SVH

// Widths of the register port and data paths
`define ESU_ADDR_W 4
`define ESU_DATA_W 32
`define ESU_LANES 4
`define ESU_CTRL_W 6
`define ESU_STRAP_W 3

// Register offsets
`define ESU_ADDR_CTRL 4'h0
`define ESU_ADDR_STAT 4'h4

// Control register fields
`define ESU_BIT_PCI_BIG 0
`define ESU_BIT_CPU_BIG 1
`define ESU_BIT_REV 2
`define ESU_BIT_W1 3
`define ESU_BIT_W2 4
`define ESU_BIT_IO 5
`define ESU_CTRL_RESET 6'h00
`define ESU_CTRL_WMASK 6'h3b

// Status register fields
`define ESU_STAT_SWAP 0
`define ESU_STAT_STEER 1
`define ESU_STAT_REGACC 2
`define ESU_STAT_CONFLICT 3
`define ESU_STAT_PCISWAP 4

// Strap port positions (pins 10, 11, 12 of the muxed bus)
`define ESU_STRAP_LEGACY 0
`define ESU_STRAP_PCI 1
`define ESU_STRAP_CPU 2

// Reset values
`define ESU_REV_DEFAULT 1'b1
`define ESU_ZERO_WORD 32'h0000_0000
`define ESU_ZERO_BE 4'h0

`endif

// ### esu_pkg.sv
// Types for the endian swap and steer unit
`include "esu_defs.svh"

package esu_pkg;

    // Complete register state of the unit
    typedef struct packed {
        logic [`ESU_CTRL_W-1:0] ctrl;
        logic strapped;
        logic conflict;
        logic [`ESU_DATA_W-1:0] rdata;
        logic int_wr_valid;
        logic [`ESU_DATA_W-1:0] int_wr_data;
        logic [`ESU_LANES-1:0] int_wr_be;
        logic cpu_rd_valid;
        logic [`ESU_DATA_W-1:0] cpu_rd_data;
        logic pci_valid;
        logic [`ESU_DATA_W-1:0] pci_data;
    } esu_state_s;

endpackage : esu_pkg

// ### esu_endian_swap_steer.sv
// Byte-order swap and steer unit between CPU bus and internal side
// How it works
// - Control bit 0 set swaps bytes on the PCI side; clear passes.
// - Control bit 1 set swaps bytes on CPU transfers unless steering; clear passes.
// - Control bit 2 reports silicon revision and gates steering.
// - Control bit 3 enables steering for window one with big endian.
// - Control bit 4 enables steering for window two with big endian.
// - Control bit 5 enables steering for the I/O window.
// - Any of the three window enables set means register access.
// - Steer only when revision, register access and big endian are 1.
// - Big endian without steering swaps; little endian does nothing.
// - Steering wins over swapping when both conditions hold.
// - Memory data stays little endian whatever the settings.
// - Internal registers and FIFOs hold little-endian data.
// - After reset the endian flags load from the strap pins.
// - Steering keeps halfwords and bytes in original lanes.
// - Bit order inside a byte never changes.
// - Swapping reverses the bytes of a word, lanes included.
// - Legacy strap high sets both endian flags.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "esu_defs.svh"

module esu_endian_swap_steer
    import esu_pkg::*;
#(
    parameter bit SILICON_REV = `ESU_REV_DEFAULT // Revision reported
) (
    input wire logic clk_sys, // System clock, 200 MHz
    input wire logic reset, // Asynchronous reset, active high
    input wire logic clk_en, // Freezes all state while low
    input wire logic [`ESU_ADDR_W-1:0] reg_addr, // Register address
    input wire logic [`ESU_DATA_W-1:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    output logic [`ESU_DATA_W-1:0] reg_rdata, // Read data, next cycle
    input wire logic [`ESU_STRAP_W-1:0] muxed_addr_data_strap, // Straps
    input wire logic cpu_wr_valid, // CPU write word valid
    input wire logic [`ESU_DATA_W-1:0] cpu_wr_data, // CPU write data
    input wire logic [`ESU_LANES-1:0] cpu_wr_be, // CPU byte lanes
    output logic int_wr_valid, // Internal write valid
    output logic [`ESU_DATA_W-1:0] int_wr_data, // Little-endian data
    output logic [`ESU_LANES-1:0] int_wr_be, // Internal byte lanes
    input wire logic int_rd_valid, // Internal read word valid
    input wire logic [`ESU_DATA_W-1:0] int_rd_data, // Little-endian data
    output logic cpu_rd_valid, // CPU read data valid
    output logic [`ESU_DATA_W-1:0] cpu_rd_data, // CPU-order read data
    input wire logic int_pci_valid, // Internal word to PCI side
    input wire logic [`ESU_DATA_W-1:0] int_pci_data, // Internal data
    output logic pci_valid, // PCI-side word valid
    output logic [`ESU_DATA_W-1:0] pci_data, // PCI-order data
    output logic cpu_swap_mode, // CPU path swapping
    output logic cpu_steer_mode // CPU path steering
);

    esu_state_s st;
    esu_state_s next_st;

    // Decoded mode bits
    logic pci_big;
    logic cpu_big;
    logic rev;
    logic reg_access;
    logic steer;
    logic swap;
    logic [`ESU_DATA_W-1:0] wr_rev_data;
    logic [`ESU_LANES-1:0] wr_rev_be;
    logic [`ESU_DATA_W-1:0] rd_rev_data;
    logic [`ESU_DATA_W-1:0] pci_rev_data;
    logic [`ESU_DATA_W-1:0] ctrl_word;
    logic [`ESU_DATA_W-1:0] stat_word;
    logic [`ESU_CTRL_W-1:0] strap_ctrl;

    // Control field taps
    assign pci_big = st.ctrl[`ESU_BIT_PCI_BIG];
    assign cpu_big = st.ctrl[`ESU_BIT_CPU_BIG];
    assign rev = st.ctrl[`ESU_BIT_REV];

    // Any window steering enable marks a register access
    assign reg_access = st.ctrl[`ESU_BIT_W1] |
                        st.ctrl[`ESU_BIT_W2] |
                        st.ctrl[`ESU_BIT_IO];

    // Steer needs all three terms; otherwise big endian swaps
    assign steer = rev & reg_access & cpu_big;
    assign swap = cpu_big & ~steer;

    // Whole bytes move between lanes; bits inside a byte never move
    for (genvar i = 0; i < `ESU_LANES; i++) begin : g_lane
        localparam int J = `ESU_LANES - 1 - i;
        assign wr_rev_data[8*i +: 8] = cpu_wr_data[8*J +: 8];
        assign wr_rev_be[i] = cpu_wr_be[J];
        assign rd_rev_data[8*i +: 8] = int_rd_data[8*J +: 8];
        assign pci_rev_data[8*i +: 8] = int_pci_data[8*J +: 8];
    end

    // Register images
    always_comb begin
        ctrl_word = `ESU_ZERO_WORD;
        ctrl_word[`ESU_CTRL_W-1:0] = st.ctrl;
        stat_word = `ESU_ZERO_WORD;
        stat_word[`ESU_STAT_SWAP] = swap;
        stat_word[`ESU_STAT_STEER] = steer;
        stat_word[`ESU_STAT_REGACC] = reg_access;
        stat_word[`ESU_STAT_CONFLICT] = st.conflict;
        stat_word[`ESU_STAT_PCISWAP] = pci_big;
    end

    // Endian flags as loaded from the straps after reset
    always_comb begin
        strap_ctrl = st.ctrl;
        strap_ctrl[`ESU_BIT_REV] = SILICON_REV;
        strap_ctrl[`ESU_BIT_PCI_BIG] =
            muxed_addr_data_strap[`ESU_STRAP_PCI] |
            muxed_addr_data_strap[`ESU_STRAP_LEGACY];
        strap_ctrl[`ESU_BIT_CPU_BIG] =
            muxed_addr_data_strap[`ESU_STRAP_CPU] |
            muxed_addr_data_strap[`ESU_STRAP_LEGACY];
    end

    // Next state of the whole unit
    always_comb begin
        next_st = st;
        // Straps caught once, in the first enabled cycle after release
        if (!st.strapped) begin
            next_st.strapped = 1'b1;
            next_st.ctrl = strap_ctrl;
            // Flag an illegal strap pair so software can see it
            next_st.conflict =
                muxed_addr_data_strap[`ESU_STRAP_LEGACY] &
                muxed_addr_data_strap[`ESU_STRAP_PCI];
        end else if (reg_wr && reg_addr == `ESU_ADDR_CTRL) begin
            // Revision bit keeps its value on writes
            next_st.ctrl = (reg_wdata[`ESU_CTRL_W-1:0] &
                            `ESU_CTRL_WMASK) |
                           (st.ctrl & ~`ESU_CTRL_WMASK);
        end
        // Read data stand for one cycle after the strobe
        if (reg_rd) begin
            case (reg_addr)
                `ESU_ADDR_CTRL: next_st.rdata = ctrl_word;
                `ESU_ADDR_STAT: next_st.rdata = stat_word;
                default: next_st.rdata = `ESU_ZERO_WORD;
            endcase
        end else begin
            next_st.rdata = `ESU_ZERO_WORD;
        end
        // CPU to internal: internal side always little endian
        next_st.int_wr_valid = cpu_wr_valid;
        if (cpu_wr_valid) begin
            if (swap) begin
                next_st.int_wr_data = wr_rev_data;
                next_st.int_wr_be = wr_rev_be;
            end else begin
                next_st.int_wr_data = cpu_wr_data;
                next_st.int_wr_be = cpu_wr_be;
            end
        end
        // Internal to CPU: the same mapping backwards
        next_st.cpu_rd_valid = int_rd_valid;
        if (int_rd_valid) begin
            next_st.cpu_rd_data = swap ? rd_rev_data : int_rd_data;
        end
        // Internal to PCI side: governed by the PCI flag alone
        next_st.pci_valid = int_pci_valid;
        if (int_pci_valid) begin
            next_st.pci_data = pci_big ? pci_rev_data : int_pci_data;
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st.ctrl <= `ESU_CTRL_RESET;
            st.strapped <= 1'b0;
            st.conflict <= 1'b0;
            st.rdata <= `ESU_ZERO_WORD;
            st.int_wr_valid <= 1'b0;
            st.int_wr_data <= `ESU_ZERO_WORD;
            st.int_wr_be <= `ESU_ZERO_BE;
            st.cpu_rd_valid <= 1'b0;
            st.cpu_rd_data <= `ESU_ZERO_WORD;
            st.pci_valid <= 1'b0;
            st.pci_data <= `ESU_ZERO_WORD;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // Outputs straight from the state
    assign reg_rdata = st.rdata;
    assign int_wr_valid = st.int_wr_valid;
    assign int_wr_data = st.int_wr_data;
    assign int_wr_be = st.int_wr_be;
    assign cpu_rd_valid = st.cpu_rd_valid;
    assign cpu_rd_data = st.cpu_rd_data;
    assign pci_valid = st.pci_valid;
    assign pci_data = st.pci_data;
    assign cpu_swap_mode = swap;
    assign cpu_steer_mode = steer;

    // Swap and steer never active together
    mode_exclusive_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        !(cpu_swap_mode && cpu_steer_mode))
        else $error("swap and steer both active");

    // Steering exactly when all three terms hold
    steer_cause_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        cpu_steer_mode == (st.ctrl[`ESU_BIT_REV] && cpu_big &&
            (st.ctrl[`ESU_BIT_W1] || st.ctrl[`ESU_BIT_W2] ||
             st.ctrl[`ESU_BIT_IO])))
        else $error("steer mode does not follow control bits");

    // Little endian CPU bus never swaps nor steers
    little_pass_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        !cpu_big |-> !cpu_swap_mode && !cpu_steer_mode)
        else $error("little endian path altered data");

    // Swapped write reverses every byte of the word
    write_swap_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        clk_en && cpu_wr_valid && cpu_swap_mode ##1 clk_en |->
        int_wr_valid &&
        int_wr_data == {$past(cpu_wr_data[7:0]),
                        $past(cpu_wr_data[15:8]),
                        $past(cpu_wr_data[23:16]),
                        $past(cpu_wr_data[31:24])} &&
        int_wr_be == {$past(cpu_wr_be[0]), $past(cpu_wr_be[1]),
                      $past(cpu_wr_be[2]), $past(cpu_wr_be[3])})
        else $error("swapped write has wrong byte order");

    // Unswapped write keeps lanes in place
    write_pass_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        clk_en && cpu_wr_valid && !cpu_swap_mode |=>
        int_wr_data == $past(cpu_wr_data) &&
        int_wr_be == $past(cpu_wr_be))
        else $error("steered write moved bytes");

    // Read path mirrors the write path
    read_swap_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        clk_en && int_rd_valid |=>
        cpu_rd_valid &&
        cpu_rd_data == ($past(cpu_swap_mode) ?
            {$past(int_rd_data[7:0]), $past(int_rd_data[15:8]),
             $past(int_rd_data[23:16]), $past(int_rd_data[31:24])} :
            $past(int_rd_data)))
        else $error("read data order wrong");

    // PCI side follows the PCI flag
    pci_order_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        clk_en && int_pci_valid |=>
        pci_data == ($past(pci_big) ?
            {$past(int_pci_data[7:0]), $past(int_pci_data[15:8]),
             $past(int_pci_data[23:16]),
             $past(int_pci_data[31:24])} :
            $past(int_pci_data)))
        else $error("pci data order wrong");

    // Revision bit survives any write
    rev_readonly_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        st.strapped && clk_en && reg_wr |=>
        st.ctrl[`ESU_BIT_REV] == $past(st.ctrl[`ESU_BIT_REV]))
        else $error("revision bit changed by write");

    // Legacy strap sets both flags at capture
    strap_legacy_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        !st.strapped && clk_en &&
        muxed_addr_data_strap[`ESU_STRAP_LEGACY] |=>
        st.strapped && pci_big && cpu_big)
        else $error("legacy strap did not set both flags");

    // Straps load the flags exactly once
    strap_load_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        !st.strapped && clk_en |=>
        cpu_big == $past(muxed_addr_data_strap[`ESU_STRAP_CPU] |
                     muxed_addr_data_strap[`ESU_STRAP_LEGACY]) &&
        pci_big == $past(muxed_addr_data_strap[`ESU_STRAP_PCI] |
                     muxed_addr_data_strap[`ESU_STRAP_LEGACY]))
        else $error("strap values not loaded");

    // Read data last one cycle only
    read_pulse_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        clk_en && !reg_rd |=> reg_rdata == `ESU_ZERO_WORD)
        else $error("read data held beyond one cycle");

endmodule : esu_endian_swap_steer

// ### esu_cpu_model.sv
// Host CPU model that drives the register port of the unit
`timescale 1ns/1ps
`include "esu_defs.svh"

module esu_cpu_model
    import esu_pkg::*;
(
    input wire logic clk_sys, // System clock
    output logic [`ESU_ADDR_W-1:0] reg_addr, // Register address
    output logic [`ESU_DATA_W-1:0] reg_wdata, // Write data
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    input wire logic [`ESU_DATA_W-1:0] reg_rdata // Read data
);
    // Idle bus at time zero
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // One-cycle write; data is scrambled once released
    task automatic wr(input logic [3:0] addr, input logic [31:0] data);
        @(posedge clk_sys);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~data;
    endtask : wr

    // One-cycle read; data is taken in the cycle after the strobe
    task automatic rd(input logic [3:0] addr, output logic [31:0] data);
        @(posedge clk_sys);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 data = reg_rdata;
    endtask : rd
endmodule : esu_cpu_model

// ### testbench.sv
// Self-checking bench for the endian swap and steer unit
`timescale 1ns/1ps
`include "esu_defs.svh"

module testbench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [2:0] strap = 3'b000;
    logic cpu_wr_valid = 1'b0, int_rd_valid = 1'b0, int_pci_valid = 1'b0;
    logic [31:0] cpu_wr_data = '0, int_rd_data = '0, int_pci_data = '0;
    logic [3:0] cpu_wr_be = 4'h0, reg_addr;
    logic [31:0] reg_wdata, reg_rdata, int_wr_data, cpu_rd_data, pci_data;
    logic reg_wr, reg_rd, int_wr_valid, cpu_rd_valid, pci_valid;
    logic [3:0] int_wr_be;
    logic cpu_swap_mode, cpu_steer_mode;
    logic [31:0] rd, d;
    logic [2:0] win;
    logic cpu_big, pci_big, steer, swap;
    logic [2:0] legal [4] = '{3'b001, 3'b100, 3'b110, 3'b000};
    logic [31:0] words [2] = '{32'hAABB_CCDD, 32'h0180_7F01};
    logic [3:0] lanes [2] = '{4'hC, 4'h1};
    int bad_count = 0, tests_run = 0;

    // Clock of 5 ns period
    always #2.5 clk_sys = ~clk_sys;

    esu_cpu_model cpu_u (.clk_sys(clk_sys), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    esu_endian_swap_steer dut_u (.clk_sys(clk_sys), .reset(reset),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .muxed_addr_data_strap(strap), .cpu_wr_valid(cpu_wr_valid),
        .cpu_wr_data(cpu_wr_data), .cpu_wr_be(cpu_wr_be),
        .int_wr_valid(int_wr_valid), .int_wr_data(int_wr_data),
        .int_wr_be(int_wr_be), .int_rd_valid(int_rd_valid),
        .int_rd_data(int_rd_data), .cpu_rd_valid(cpu_rd_valid),
        .cpu_rd_data(cpu_rd_data), .int_pci_valid(int_pci_valid),
        .int_pci_data(int_pci_data), .pci_valid(pci_valid),
        .pci_data(pci_data), .cpu_swap_mode(cpu_swap_mode),
        .cpu_steer_mode(cpu_steer_mode));

    // Full byte reverse of a word, bits inside bytes kept
    function automatic logic [31:0] sw(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction : sw

    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Counts and verdict
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // Reset for two cycles, then let the strap capture edge pass
    task automatic do_reset(input logic [2:0] s);
        strap <= s;
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
    endtask : do_reset

    // One word on all three data paths
    task automatic xfer(input logic [31:0] v, input logic [3:0] be);
        @(posedge clk_sys);
        cpu_wr_valid <= 1'b1;
        int_rd_valid <= 1'b1;
        int_pci_valid <= 1'b1;
        cpu_wr_data <= v;
        cpu_wr_be <= be;
        int_rd_data <= ~v;
        int_pci_data <= v;
        @(posedge clk_sys);
        cpu_wr_valid <= 1'b0;
        int_rd_valid <= 1'b0;
        int_pci_valid <= 1'b0;
        #1;
    endtask : xfer

    // Watchdog
    initial begin
        #20000;
        bad_count++;
        results();
    end

    // Test sequence
    initial begin
        for (int i = 0; i < 4; i++) begin
            do_reset(legal[i]);
            cpu_u.rd(`ESU_ADDR_CTRL, rd);
            d = {29'h0, 1'b1, legal[i][2] | legal[i][0],
                legal[i][1] | legal[i][0]};
            check("ctrl_strap", rd, d);
            check("swap_strap", cpu_swap_mode, d[1]);
        end
        $display("test strap done");
        cpu_u.wr(`ESU_ADDR_CTRL, 32'hFFFF_FFFF);
        cpu_u.rd(`ESU_ADDR_CTRL, rd);
        check("ctrl_ones", rd, 32'h0000_003F);
        cpu_u.wr(`ESU_ADDR_CTRL, 32'h0000_0000);
        cpu_u.rd(`ESU_ADDR_CTRL, rd);
        check("ctrl_zero", rd, 32'h0000_0004);
        cpu_u.wr(4'h8, 32'hFFFF_FFFF);
        cpu_u.rd(4'h8, rd);
        check("unmapped", rd, 32'h0000_0000);
        $display("test register done");
        for (int k = 0; k < 8; k++) begin
            cpu_big = k[0];
            pci_big = k[1] ^ k[0];
            win = 3'b000;
            if (k[2:1] != 0) win[k[2:1] - 1] = 1'b1;
            steer = cpu_big & (win != 3'b000);
            swap = cpu_big & !steer;
            cpu_u.wr(`ESU_ADDR_CTRL, {26'h0, win, 1'b0, cpu_big, pci_big});
            cpu_u.rd(`ESU_ADDR_STAT, rd);
            d = {27'h0, pci_big, 1'b0, win != 3'b000, steer, swap};
            check("status", rd, d);
            check("swap_mode", cpu_swap_mode, swap);
            check("steer_mode", cpu_steer_mode, steer);
            for (int j = 0; j < 2; j++) begin
                xfer(words[j], lanes[j]);
                d = swap ? sw(words[j]) : words[j];
                check("wr_valid", int_wr_valid, 1'b1);
                check("rd_valid", cpu_rd_valid, 1'b1);
                check("pci_valid", pci_valid, 1'b1);
                check("wr_data", int_wr_data, d);
                check("wr_be", int_wr_be, swap ? {lanes[j][0], lanes[j][1],
                    lanes[j][2], lanes[j][3]} : lanes[j]);
                d = swap ? sw(~words[j]) : ~words[j];
                check("rd_data", cpu_rd_data, d);
                d = pci_big ? sw(words[j]) : words[j];
                check("pci_data", pci_data, d);
            end
            // Valid outputs stand for a single cycle only
            @(posedge clk_sys);
            #1;
            check("wr_idle", int_wr_valid, 1'b0);
            check("rd_idle", cpu_rd_valid, 1'b0);
            check("pci_idle", pci_valid, 1'b0);
        end
        $display("test modes done");
        // A control write while the clock enable is low must be lost
        cpu_u.wr(`ESU_ADDR_CTRL, 32'h0000_0000);
        @(posedge clk_sys);
        clk_en <= 1'b0;
        cpu_u.wr(`ESU_ADDR_CTRL, 32'h0000_0003);
        clk_en <= 1'b1;
        cpu_u.rd(`ESU_ADDR_CTRL, rd);
        check("ctrl_frozen", rd, 32'h0000_0004);
        $display("test freeze done");
        results();
    end
endmodule : testbench
